//--- dsp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module dsp_host_model (
   output logic ser_clk,
   output logic ser_data,
   output logic load_strobe
);
   // link idles with the clock still
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      load_strobe = 1'b0;
   end
   // one bit: data set up while clock low, sampled on the rise
   task automatic bitout(input logic b);
      ser_data = b;
      #16 ser_clk = 1'b1;
      #32 ser_clk = 1'b0;
      #16;
   endtask
   // optional stray bits, then a whole word msb first, then the strobe
   task automatic send(input logic [17:0] w, input logic [3:0] junk, input bit lead);
      int i;
      if (lead) for (i = 3; i >= 0; i--) bitout(junk[i]);
      for (i = 17; i >= 0; i--) bitout(w[i]);
      ser_data = ~ser_data; // data no longer valid
      #20 load_strobe = 1'b1;
      #100 load_strobe = 1'b0;
   endtask
endmodule // dsp_host_model
`default_nettype wire

//--- dsp_pkg.sv
package dsp_pkg;
   // shift register layout
   localparam int SHIFT_W = 18;
   localparam int PAY_MSB = 17;
   localparam int PAY_LSB = 2;
   localparam int SEL_MSB = 1;
   localparam int SEL_LSB = 0;
   localparam int WORD4_MSB = 17;
   localparam int WORD4_LSB = 14;
   localparam int DIV12_MSB = 13;
   localparam int DIV12_LSB = 2;
   localparam int BIN12_MSB = 17;
   localparam int BIN12_LSB = 6;
   localparam int SW4_MSB = 5;
   localparam int SW4_LSB = 2;
   localparam int BIN11_MSB = 17;
   localparam int BIN11_LSB = 7;
   localparam int SW5_MSB = 6;
   localparam int SW5_LSB = 2;
   // latch select codes
   localparam logic [1:0] SEL_AUX_R = 2'h0;
   localparam logic [1:0] SEL_AUX_N = 2'h1;
   localparam logic [1:0] SEL_MAIN_R = 2'h2;
   localparam logic [1:0] SEL_MAIN_N = 2'h3;
   // pump control word bit positions inside the 4-bit word
   localparam int PCW_AUX_GAIN = 3;
   localparam int PCW_MAIN_GAIN = 2;
   localparam int PCW_AUX_POL = 1;
   localparam int PCW_MAIN_POL = 0;
   // variant codes
   localparam logic [1:0] VAR_2G = 2'h0;
   localparam logic [1:0] VAR_1G1 = 2'h1;
   localparam logic [1:0] VAR_500M = 2'h2;
   // prescaler moduli
   localparam logic [5:0] MOD_2G = 6'h20;
   localparam logic [5:0] MOD_1G1 = 6'h10;
   localparam logic [5:0] MOD_500M = 6'h08;
   // multifunction output select codes (upper three bits)
   localparam logic [2:0] MFO_CONST = 3'h0;
   localparam logic [2:0] MFO_MAIN_LD = 3'h1;
   localparam logic [2:0] MFO_AUX_LD = 3'h2;
   localparam logic [2:0] MFO_BOTH_LD = 3'h3;
   localparam logic [2:0] MFO_MAIN_REF = 3'h4;
   localparam logic [2:0] MFO_AUX_REF = 3'h5;
   localparam logic [2:0] MFO_MAIN_FB = 3'h6;
   localparam logic [2:0] MFO_AUX_FB = 3'h7;
   localparam logic [15:0] LATCH_RST = 16'h0000;
   typedef enum logic [2:0] {
      DSP_IDLE = 3'b001,
      DSP_LOAD = 3'b010,
      DSP_WAIT = 3'b100
   } dsp_xfer_e;
endpackage

//--- dsp_serial_regs.sv
// Contract
// - 18-bit shift register, upper 16 payload, lowest 2 select latch.
// - words arrive most significant bit first, select bits last.
// - strobe rising edge copies payload into exactly one of four latches.
// - code 00 loads output select word and auxiliary reference divisor.
// - code 10 loads pump control word and main reference divisor.
// - code 01 loads auxiliary binary 12 bits and swallow 4 bits.
// - code 11 loads main feedback; 2 GHz variant splits 11/5 bits.
// - 1.1 GHz auxiliary swallow accepts 0 to 15.
// - 500 MHz auxiliary swallow ignores its top bit.
// - output select word picks what the multifunction output drives.
// - pump control word sets both pump gains and detector polarities.
// - serial data sampled on each serial clock rising edge.
// - new divide value reaches its counter only when it hits zero.
// - pump word bits: aux gain, main gain, aux pol, main pol.
// - feedback ratio is modulus times binary value plus swallow.
`timescale 1ns/10ps
`default_nettype none
module dsp_serial_regs
   import dsp_pkg::*;
#(
   parameter logic [1:0] MAIN_VARIANT = VAR_2G,
   parameter logic [1:0] AUX_VARIANT = VAR_500M
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire logic load_strobe,
   input wire logic main_ref_zero,
   input wire logic aux_ref_zero,
   input wire logic main_fb_zero,
   input wire logic aux_fb_zero,
   input wire logic main_lock,
   input wire logic aux_lock,
   input wire logic main_ref_out,
   input wire logic aux_ref_out,
   input wire logic main_fb_out,
   input wire logic aux_fb_out,
   output logic [11:0] main_ref_divisor,
   output logic [11:0] aux_ref_divisor,
   output logic [16:0] main_fb_ratio,
   output logic [16:0] aux_fb_ratio,
   output logic [11:0] main_binary_value,
   output logic [4:0] main_swallow_value,
   output logic [11:0] aux_binary_value,
   output logic [3:0] aux_swallow_value,
   output logic aux_pump_gain_sel,
   output logic main_pump_gain_sel,
   output logic aux_detector_polarity,
   output logic main_detector_polarity,
   output logic [3:0] multifunction_output_select,
   output logic multifunction_out
);

   // feedback ratio = modulus * binary + swallow
   function automatic logic [16:0] fb_ratio(input logic [5:0] modulus,
                                            input logic [11:0] bin,
                                            input logic [4:0] sw);
      logic [17:0] prod;
      prod = 18'(modulus) * 18'(bin);
      return 17'(prod + 18'(sw));
   endfunction

   function automatic logic [5:0] modulus_of(input logic [1:0] variant);
      case (variant)
         VAR_2G: return MOD_2G;
         VAR_1G1: return MOD_1G1;
         default: return MOD_500M;
      endcase
   endfunction

   // ---------------- serial clock domain ----------------
   logic [SHIFT_W-1:0] shift_q, shift_d;

   // shift in msb first, oldest bits fall off the top
   always_comb begin
      shift_d = {shift_q[SHIFT_W-2:0], ser_data};
   end

   always_ff @(posedge ser_clk or posedge reset) begin
      if (reset) begin
         shift_q <= '0;
      end else begin
         shift_q <= shift_d;
      end
   end

   // ---------------- system clock domain ----------------
   // strobe synchroniser: three stages, edge when second and third agree
   logic [2:0] le_sync_q, le_sync_d;
   logic le_level_q, le_level_d;
   logic le_rise;

   always_comb begin
      le_sync_d = {le_sync_q[1:0], load_strobe};
      le_level_d = le_level_q;
      if (le_sync_q[1] == le_sync_q[2]) begin
         le_level_d = le_sync_q[2];
      end
   end

   assign le_rise = le_level_d & ~le_level_q;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         le_sync_q <= '0;
         le_level_q <= 1'b0;
      end else begin
         le_sync_q <= le_sync_d;
         le_level_q <= le_level_d;
      end
   end

   // word capture: shift register is stable while strobe is high (no serial clocks)
   dsp_xfer_e state_q, state_d;
   logic [SHIFT_W-1:0] cap_q, cap_d;
   logic [15:0] aux_r_q, aux_r_d, main_r_q, main_r_d;
   logic [15:0] aux_n_q, aux_n_d, main_n_q, main_n_d;

   always_comb begin
      state_d = state_q;
      cap_d = cap_q;
      aux_r_d = aux_r_q;
      main_r_d = main_r_q;
      aux_n_d = aux_n_q;
      main_n_d = main_n_q;
      case (state_q)
         DSP_IDLE: begin
            if (le_rise) begin
               state_d = DSP_LOAD;
            end
         end
         DSP_LOAD: begin
            cap_d = shift_q; // multi-cycle path, word held static by the host
            state_d = DSP_WAIT;
         end
         DSP_WAIT: begin
            case (cap_q[SEL_MSB:SEL_LSB])
               SEL_AUX_R: aux_r_d = cap_q[PAY_MSB:PAY_LSB];
               SEL_AUX_N: aux_n_d = cap_q[PAY_MSB:PAY_LSB];
               SEL_MAIN_R: main_r_d = cap_q[PAY_MSB:PAY_LSB];
               default: main_n_d = cap_q[PAY_MSB:PAY_LSB];
            endcase
            state_d = DSP_IDLE;
         end
         default: state_d = DSP_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q <= DSP_IDLE;
         cap_q <= '0;
         aux_r_q <= LATCH_RST;
         main_r_q <= LATCH_RST;
         aux_n_q <= LATCH_RST;
         main_n_q <= LATCH_RST;
      end else begin
         state_q <= state_d;
         cap_q <= cap_d;
         aux_r_q <= aux_r_d;
         main_r_q <= main_r_d;
         aux_n_q <= aux_n_d;
         main_n_q <= main_n_d;
      end
   end

   // field decode of the latches, offset by the two select bits
   logic [11:0] aux_r_div, main_r_div, aux_bin, main_bin;
   logic [4:0] aux_sw, main_sw;
   logic [3:0] mfo_word, pump_word;

   always_comb begin
      mfo_word = aux_r_q[WORD4_MSB-PAY_LSB:WORD4_LSB-PAY_LSB];
      aux_r_div = aux_r_q[DIV12_MSB-PAY_LSB:DIV12_LSB-PAY_LSB];
      pump_word = main_r_q[WORD4_MSB-PAY_LSB:WORD4_LSB-PAY_LSB];
      main_r_div = main_r_q[DIV12_MSB-PAY_LSB:DIV12_LSB-PAY_LSB];
      aux_bin = aux_n_q[BIN12_MSB-PAY_LSB:BIN12_LSB-PAY_LSB];
      aux_sw = {1'b0, aux_n_q[SW4_MSB-PAY_LSB:SW4_LSB-PAY_LSB]};
      if (AUX_VARIANT == VAR_500M) begin
         aux_sw[3] = 1'b0;
      end
      if (MAIN_VARIANT == VAR_2G) begin
         main_bin = {1'b0, main_n_q[BIN11_MSB-PAY_LSB:BIN11_LSB-PAY_LSB]};
         main_sw = main_n_q[SW5_MSB-PAY_LSB:SW5_LSB-PAY_LSB];
      end else begin
         main_bin = main_n_q[BIN12_MSB-PAY_LSB:BIN12_LSB-PAY_LSB];
         main_sw = {1'b0, main_n_q[SW4_MSB-PAY_LSB:SW4_LSB-PAY_LSB]};
      end
   end

   // counter-side zero flags are pins: three-stage filters
   logic [3:0] z_s1_q, z_s2_q, z_s3_q, z_lvl_q, z_lvl_d, z_s1_d;

   always_comb begin
      z_s1_d = {aux_fb_zero, main_fb_zero, aux_ref_zero, main_ref_zero};
      z_lvl_d = z_lvl_q;
      for (int i = 0; i < 4; i++) begin
         if (z_s2_q[i] == z_s3_q[i]) begin
            z_lvl_d[i] = z_s3_q[i];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         z_s1_q <= '0;
         z_s2_q <= '0;
         z_s3_q <= '0;
         z_lvl_q <= '0;
      end else begin
         z_s1_q <= z_s1_d;
         z_s2_q <= z_s1_q;
         z_s3_q <= z_s2_q;
         z_lvl_q <= z_lvl_d;
      end
   end

   // active counter values: reload only when the counter hits zero
   logic [11:0] mref_q, mref_d, aref_q, aref_d;
   logic [11:0] mbin_q, mbin_d, abin_q, abin_d;
   logic [4:0] msw_q, msw_d;
   logic [3:0] asw_q, asw_d;
   logic [16:0] mratio_q, mratio_d, aratio_q, aratio_d;

   always_comb begin
      mref_d = mref_q;
      aref_d = aref_q;
      mbin_d = mbin_q;
      msw_d = msw_q;
      abin_d = abin_q;
      asw_d = asw_q;
      if (z_lvl_d[0] & ~z_lvl_q[0]) begin
         mref_d = main_r_div;
      end
      if (z_lvl_d[1] & ~z_lvl_q[1]) begin
         aref_d = aux_r_div;
      end
      if (z_lvl_d[2] & ~z_lvl_q[2]) begin
         mbin_d = main_bin;
         msw_d = main_sw;
      end
      if (z_lvl_d[3] & ~z_lvl_q[3]) begin
         abin_d = aux_bin;
         asw_d = aux_sw[3:0];
      end
      // ratios follow the active values so that they leave the block from flops
      mratio_d = fb_ratio(modulus_of(MAIN_VARIANT), mbin_d, msw_d);
      aratio_d = fb_ratio(modulus_of(AUX_VARIANT), abin_d, {1'b0, asw_d});
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mref_q <= '0;
         aref_q <= '0;
         mbin_q <= '0;
         msw_q <= '0;
         abin_q <= '0;
         asw_q <= '0;
         mratio_q <= '0;
         aratio_q <= '0;
      end else begin
         mref_q <= mref_d;
         aref_q <= aref_d;
         mbin_q <= mbin_d;
         msw_q <= msw_d;
         abin_q <= abin_d;
         asw_q <= asw_d;
         mratio_q <= mratio_d;
         aratio_q <= aratio_d;
      end
   end

   // multifunction output: select among constants, locks and counter outputs
   logic mfo_q, mfo_d;

   always_comb begin
      case (mfo_word[3:1])
         MFO_CONST: mfo_d = mfo_word[0];
         MFO_MAIN_LD: mfo_d = main_lock;
         MFO_AUX_LD: mfo_d = aux_lock;
         MFO_BOTH_LD: mfo_d = main_lock & aux_lock;
         MFO_MAIN_REF: mfo_d = main_ref_out;
         MFO_AUX_REF: mfo_d = aux_ref_out;
         MFO_MAIN_FB: mfo_d = main_fb_out;
         default: mfo_d = aux_fb_out;
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mfo_q <= 1'b0;
      end else begin
         mfo_q <= mfo_d;
      end
   end

   // outputs
   assign main_ref_divisor = mref_q;
   assign aux_ref_divisor = aref_q;
   assign main_binary_value = mbin_q;
   assign main_swallow_value = msw_q;
   assign aux_binary_value = abin_q;
   assign aux_swallow_value = asw_q;
   assign main_fb_ratio = mratio_q;
   assign aux_fb_ratio = aratio_q;
   assign aux_pump_gain_sel = pump_word[PCW_AUX_GAIN];
   assign main_pump_gain_sel = pump_word[PCW_MAIN_GAIN];
   assign aux_detector_polarity = pump_word[PCW_AUX_POL];
   assign main_detector_polarity = pump_word[PCW_MAIN_POL];
   assign multifunction_output_select = mfo_word;
   assign multifunction_out = mfo_q;

endmodule // dsp_serial_regs
`default_nettype wire

//--- dsp_serial_regs_checker.sv
`timescale 1ns/10ps
`default_nettype none
module dsp_serial_regs_checker
   import dsp_pkg::*;
#(
   parameter logic [1:0] MAIN_VARIANT = VAR_2G,
   parameter logic [1:0] AUX_VARIANT = VAR_500M
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic load_strobe,
   input wire logic main_ref_zero,
   input wire logic aux_fb_zero,
   input wire logic main_lock,
   input wire logic [11:0] main_ref_divisor,
   input wire logic [16:0] main_fb_ratio,
   input wire logic [16:0] aux_fb_ratio,
   input wire logic [11:0] main_binary_value,
   input wire logic [4:0] main_swallow_value,
   input wire logic [11:0] aux_binary_value,
   input wire logic [3:0] aux_swallow_value,
   input wire logic main_pump_gain_sel,
   input wire logic [3:0] multifunction_output_select,
   input wire logic multifunction_out
);
   localparam logic [5:0] MAIN_MOD = (MAIN_VARIANT == VAR_2G) ? MOD_2G :
      (MAIN_VARIANT == VAR_1G1) ? MOD_1G1 : MOD_500M;
   localparam logic [5:0] AUX_MOD = (AUX_VARIANT == VAR_2G) ? MOD_2G :
      (AUX_VARIANT == VAR_1G1) ? MOD_1G1 : MOD_500M;
   logic [7:0] zr_q, zr_d, zf_q, zf_d, st_q, st_d;
   // short history of the reload and strobe pins
   always_comb begin
      zr_d = {zr_q[6:0], main_ref_zero};
      zf_d = {zf_q[6:0], aux_fb_zero};
      st_d = {st_q[6:0], load_strobe};
   end
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         zr_q <= 8'h00;
         zf_q <= 8'h00;
         st_q <= 8'h00;
      end else begin
         zr_q <= zr_d;
         zf_q <= zf_d;
         st_q <= st_d;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   a_main_ratio_sum:
      assert property (main_fb_ratio == 17'(MAIN_MOD) * 17'(main_binary_value)
         + 17'(main_swallow_value)) else $error("main feedback ratio wrong");
   a_aux_ratio_sum:
      assert property (aux_fb_ratio == 17'(AUX_MOD) * 17'(aux_binary_value)
         + 17'(aux_swallow_value)) else $error("aux feedback ratio wrong");
   a_aux_swallow_top:
      assert property ((AUX_VARIANT != VAR_500M) || !aux_swallow_value[3])
         else $error("aux swallow top bit used");
   a_main_binary_top:
      assert property ((MAIN_VARIANT != VAR_2G) || !main_binary_value[11])
         else $error("main binary top bit used");
   a_ref_waits_zero:
      assert property ($changed(main_ref_divisor) |-> |zr_q)
         else $error("main divisor changed without reload");
   a_fb_waits_zero:
      assert property ($changed(aux_binary_value) || $changed(aux_swallow_value) |-> |zf_q)
         else $error("aux feedback changed without reload");
   a_pump_needs_strobe:
      assert property ($changed(main_pump_gain_sel) |-> |st_q)
         else $error("pump gain changed without strobe");
   a_mfo_low_level:
      assert property ($past(multifunction_output_select) == 4'h0 |-> !multifunction_out)
         else $error("output not low");
   a_mfo_high_level:
      assert property ($past(multifunction_output_select) == 4'h1 |-> multifunction_out)
         else $error("output not high");
   a_mfo_main_lock:
      assert property ($past(multifunction_output_select[3:1]) == 3'h1
         |-> multifunction_out == $past(main_lock)) else $error("output not main lock");
endmodule // dsp_serial_regs_checker
bind dsp_serial_regs dsp_serial_regs_checker #(.MAIN_VARIANT(MAIN_VARIANT),
   .AUX_VARIANT(AUX_VARIANT)) chk_u (.sys_clk(sys_clk), .reset(reset),
   .load_strobe(load_strobe), .main_ref_zero(main_ref_zero), .aux_fb_zero(aux_fb_zero),
   .main_lock(main_lock), .main_ref_divisor(main_ref_divisor), .main_fb_ratio(main_fb_ratio),
   .aux_fb_ratio(aux_fb_ratio), .main_binary_value(main_binary_value),
   .main_swallow_value(main_swallow_value), .aux_binary_value(aux_binary_value),
   .aux_swallow_value(aux_swallow_value), .main_pump_gain_sel(main_pump_gain_sel),
   .multifunction_output_select(multifunction_output_select),
   .multifunction_out(multifunction_out));
`default_nettype wire

//--- dual_synth_serial_program_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module dual_synth_serial_program_regs_tb_top;
   import dsp_pkg::*;
   logic sys_clk, reset;
   logic [3:0] zr;
   logic [5:0] src;
   wire ser_clk, ser_data, load_strobe;
   logic [11:0] mrd, ard, mb, ab;
   logic [4:0] ms;
   logic [3:0] asw, sel;
   logic [16:0] mr, ar;
   logic [16:0] mr2, ar2;
   logic [11:0] mb2, ab2, e2_mb = '0, p2_mb = '0;
   logic [4:0] ms2, e2_ms = '0, p2_ms = '0;
   logic [3:0] asw2, e2_as = '0, p2_as = '0;
   logic pg_a, pg_m, pol_a, pol_m, mfo;
   logic [11:0] e_mrd = '0, e_ard = '0, e_mb = '0, e_ab = '0, p_mrd = '0, p_ard = '0;
   logic [11:0] p_mb = '0, p_ab = '0;
   logic [4:0] e_ms = '0, p_ms = '0;
   logic [3:0] e_as = '0, p_as = '0, e_pw = '0, e_sel = '0;
   logic [17:0] w;
   logic [99:0] exp_q[$];
   int miscompares = 0, checks = 0;
   event obs_ev;
   dsp_host_model host_u (.ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe));
   dsp_serial_regs #(.MAIN_VARIANT(VAR_2G), .AUX_VARIANT(VAR_500M)) dut_u (
      .sys_clk(sys_clk), .reset(reset), .ser_clk(ser_clk), .ser_data(ser_data),
      .load_strobe(load_strobe), .main_ref_zero(zr[2]), .aux_ref_zero(zr[0]),
      .main_fb_zero(zr[3]), .aux_fb_zero(zr[1]), .main_lock(src[5]), .aux_lock(src[4]),
      .main_ref_out(src[3]), .aux_ref_out(src[2]), .main_fb_out(src[1]), .aux_fb_out(src[0]),
      .main_ref_divisor(mrd), .aux_ref_divisor(ard), .main_fb_ratio(mr), .aux_fb_ratio(ar),
      .main_binary_value(mb), .main_swallow_value(ms), .aux_binary_value(ab),
      .aux_swallow_value(asw), .aux_pump_gain_sel(pg_a), .main_pump_gain_sel(pg_m),
      .aux_detector_polarity(pol_a), .main_detector_polarity(pol_m),
      .multifunction_output_select(sel), .multifunction_out(mfo));
   // second copy in the 1.1 GHz variants: 12/4 main split and full aux swallow
   dsp_serial_regs #(.MAIN_VARIANT(VAR_1G1), .AUX_VARIANT(VAR_1G1)) dut_alt_u (
      .sys_clk(sys_clk), .reset(reset), .ser_clk(ser_clk), .ser_data(ser_data),
      .load_strobe(load_strobe), .main_ref_zero(zr[2]), .aux_ref_zero(zr[0]),
      .main_fb_zero(zr[3]), .aux_fb_zero(zr[1]), .main_lock(src[5]), .aux_lock(src[4]),
      .main_ref_out(src[3]), .aux_ref_out(src[2]), .main_fb_out(src[1]), .aux_fb_out(src[0]),
      .main_ref_divisor(), .aux_ref_divisor(), .main_fb_ratio(mr2), .aux_fb_ratio(ar2),
      .main_binary_value(mb2), .main_swallow_value(ms2), .aux_binary_value(ab2),
      .aux_swallow_value(asw2), .aux_pump_gain_sel(), .main_pump_gain_sel(),
      .aux_detector_polarity(), .main_detector_polarity(),
      .multifunction_output_select(), .multifunction_out());
   always #2.5 sys_clk = ~sys_clk;
   // expected level of the multifunction output
   function automatic logic mfo_exp(input logic [3:0] s, input logic [5:0] v);
      case (s[3:1])
         3'h0: return s[0];
         3'h1: return v[5];
         3'h2: return v[4];
         3'h3: return v[5] & v[4];
         3'h4: return v[3];
         3'h5: return v[2];
         3'h6: return v[1];
         default: return v[0];
      endcase
   endfunction
   task automatic check(input logic [99:0] got, input logic [99:0] want);
      checks++;
      if (got !== want) begin
         miscompares++;
         $display("BAD %0t outputs %h expected %h", $time, got, want);
      end
   endtask
   task automatic results();
      if (miscompares == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // record the expected port picture and wake the monitor
   task automatic note();
      exp_q.push_back({e_mrd, e_ard, e_mb, e_ms, e_ab, e_as, e_pw, e_sel, mfo_exp(e_sel, src),
         17'(MOD_2G) * 17'(e_mb) + 17'(e_ms), 17'(MOD_500M) * 17'(e_ab) + 17'(e_as)});
      exp_q.push_back(100'({e2_mb, e2_ms, e_ab, e2_as, 17'(MOD_1G1) * 17'(e2_mb) + 17'(e2_ms),
         17'(MOD_1G1) * 17'(e_ab) + 17'(e2_as)}));
      ->obs_ev;
   endtask
   // monitor compares every observed picture with the oldest note
   always begin
      @(obs_ev);
      check({mrd, ard, mb, ms, ab, asw, pg_a, pg_m, pol_a, pol_m, sel, mfo, mr, ar},
         exp_q.pop_front());
      check(100'({mb2, ms2, ab2, asw2, mr2, ar2}), exp_q.pop_front());
   end
   // watchdog
   initial begin
      #200000;
      miscompares++;
      results();
   end
   // main sequence
   initial begin
      sys_clk = 1'b0;
      reset = 1'b1;
      zr = 4'h0;
      src = 6'h00;
      void'($urandom(46));
      repeat (10) @(negedge sys_clk);
      reset = 1'b0;
      repeat (2) @(negedge sys_clk);
      note();
      for (int i = 0; i < 64; i++) begin
         src = 6'($urandom);
         w = 18'($urandom);
         w[17:14] = 4'(i >> 2); // every select and pump word
         w[1:0] = 2'(i); // every latch code
         if (w[1:0] == SEL_AUX_N && w[17:6] < 12'h00f) w[17:6] = 12'h00f;
         if (w[1:0] == SEL_MAIN_N && w[17:7] < 11'h01f) w[17:7] = 11'h01f;
         if (!w[0] && w[13:2] < 12'h002) w[13:2] = 12'h002;
         host_u.send(w, 4'($urandom), i[3]);
         repeat (12) @(negedge sys_clk);
         case (w[1:0])
            SEL_AUX_R: begin
               e_sel = w[17:14];
               p_ard = w[13:2];
            end
            SEL_AUX_N: begin
               p_ab = w[17:6];
               p_as = {1'b0, w[4:2]};
               p2_as = w[5:2];
            end
            SEL_MAIN_R: begin
               e_pw = w[17:14];
               p_mrd = w[13:2];
            end
            default: begin
               p_mb = {1'b0, w[17:7]};
               p_ms = w[6:2];
               p2_mb = w[17:6];
               p2_ms = {1'b0, w[5:2]};
            end
         endcase
         note(); // active divide values still the old ones
         zr[w[1:0]] = 1'b1;
         repeat (6) @(negedge sys_clk);
         zr = 4'h0;
         repeat (8) @(negedge sys_clk);
         e_ard = p_ard;
         e_mrd = p_mrd;
         e_ab = p_ab;
         e_as = p_as;
         e_mb = p_mb;
         e_ms = p_ms;
         e2_mb = p2_mb;
         e2_ms = p2_ms;
         e2_as = p2_as;
         note(); // reload moved the latch into the counter
      end
      repeat (4) @(negedge sys_clk);
      results();
   end
endmodule // dual_synth_serial_program_regs_tb_top
`default_nettype wire
